// ==== rtl/charger_state_status_logic.v ====
// charger state machine, indicator, adapter class and status reporting
`timescale 1ns/100ps
`include "charger_consts.vh"
module charger_state_status_logic #(
  parameter DEGLITCH_CYC = 32'd600000,
  parameter PREQUAL_CYC = 32'd36000000,
  parameter WATCHDOG_CYC = 32'd1600000000,
  parameter BLINK_PERIOD = `BLINK_PERIOD_CYC,
  parameter BLINK_SHORT = `BLINK_SHORT_CYC,
  parameter BLINK_HALF = `BLINK_HALF_CYC
) (
  // clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // global shutdown event
  input wire global_shutdown,
  // analog comparator results
  input wire source_valid,
  input wire battery_detect_n,
  input wire above_deadbatt,
  input wire above_lowbatt,
  input wire above_batt_reg,
  input wire input_below_reg,
  input wire vreg_active,
  // otp polarity of protection driver
  input wire otp_ovp_polarity,
  // adapter detection signature
  input wire [2:0] adapter_sig,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // outputs
  output reg charge_indicator_out,
  output reg buck_on,
  output reg charger_input_on,
  output reg ovp_drive,
  output reg charger_irq,
  output reg bypass_irq,
  output reg [2:0] adapter_type
);
  // one-hot charge states
  // the state word is also what software reads back as status,
  // so every state keeps exactly one bit set
  // idle: no source, no battery, or charger switched off
  // dead: battery below the dead threshold, short blink
  // low: battery between dead and low threshold, short blink
  // fast cc: constant current, indicator steady on
  // fast cv: constant voltage, indicator steady on
  // timer fault: prequal lasted too long, left by chg_on clear
  // watchdog suspend: host stopped servicing, left by clear write
  // topoff and done are handled outside this block
  localparam ST_IDLE = 7'b0000001;
  localparam ST_DEADB = 7'b0000010;
  localparam ST_LOWB = 7'b0000100;
  localparam ST_FASTCC = 7'b0001000;
  localparam ST_FASTCV = 7'b0010000;
  localparam ST_TFAULT = 7'b0100000;
  localparam ST_WDSUSP = 7'b1000000;
  // adapter types
  // the class code equals the detection signature for known sources,
  // anything outside the five classes reads as no adapter
  localparam AD_NONE = 3'd0;
  localparam AD_DCP = 3'd1;
  localparam AD_NCDCP = 3'd2;
  localparam AD_CDP = 3'd3;
  localparam AD_SDP_LO = 3'd4;
  localparam AD_SDP_HI = 3'd5;

  reg [6:0] state_q; // charge state
  reg [6:0] state_d;
  reg [7:0] ctrl_q; // control bits
  reg [7:0] ilim_q; // input current limit setting
  reg [31:0] dg_cnt_q; // deglitch counter
  reg dg_done_q; // deglitch already reported
  reg [31:0] pq_cnt_q; // prequal timer
  reg [31:0] wd_cnt_q; // watchdog timer
  reg [31:0] blink_q; // blink phase counter
  reg charger_ok_flag_q; // charger ok
  reg bypass_ok_flag_q; // bypass ok
  reg [3:0] charger_detail_field_q; // charger detail
  reg [3:0] bypass_detail_field_q; // bypass detail
  reg vreg_prev_q; // regulation edge detect
  reg ind_d; // next indicator level
  // watchdog has run out while enabled
  wire wd_expired;
  // battery seen on the detect pin
  wire bat_present;
  // reset or global shutdown
  wire shutdown;

  // battery present when detect pin is pulled low
  // an open pin floats high, so absence is the safe default
  // shutdown merges the reset pin and the global shutdown event,
  // both put every control bit back to its reset value
  // the watchdog only counts while software has enabled it
  assign bat_present = ~battery_detect_n;
  assign shutdown = rst | global_shutdown;
  assign wd_expired = ctrl_q[`CTRL_WD_EN] && (wd_cnt_q >= WATCHDOG_CYC);

  // decode of signature to adapter class
  // kept as a function so the mapping lives in one place
  // and unknown codes always fall to no adapter
  function [2:0] classify;
    input [2:0] sig;
    begin
      case (sig)
        3'd1: classify = AD_DCP;
        3'd2: classify = AD_NCDCP;
        3'd3: classify = AD_CDP;
        3'd4: classify = AD_SDP_LO;
        3'd5: classify = AD_SDP_HI;
        default: classify = AD_NONE;
      endcase
    end
  endfunction

  // next charge state
  // priority inside each charging state: watchdog first, then
  // timeout, then battery voltage progress
  // a watchdog expiry must win so a hung host always stops charge
  // source or battery loss overrides everything at the end
  always @* begin
    state_d = state_q;
    case (state_q)
      // idle: wait for source, battery and charger switched on,
      // then enter the state that matches the battery voltage
      ST_IDLE: begin
        // only start with valid source and battery present
        if (source_valid && bat_present && ctrl_q[`CTRL_CHG_ON]) begin
          state_d = above_deadbatt ? (above_lowbatt ? ST_FASTCC : ST_LOWB) : ST_DEADB;
        end
      end
      // dead battery prequalification
      ST_DEADB: begin
        if (wd_expired) begin
          state_d = ST_WDSUSP;
        end else if (pq_cnt_q >= PREQUAL_CYC) begin
          state_d = ST_TFAULT;
        end else if (above_deadbatt) begin
          state_d = ST_LOWB;
        end
      end
      // low battery prequalification, shares the prequal timeout
      ST_LOWB: begin
        if (wd_expired) begin
          state_d = ST_WDSUSP;
        end else if (pq_cnt_q >= PREQUAL_CYC) begin
          state_d = ST_TFAULT;
        end else if (above_lowbatt) begin
          state_d = ST_FASTCC;
        end
      end
      // fast charge constant current
      ST_FASTCC: begin
        if (wd_expired) begin
          state_d = ST_WDSUSP;
        end else if (above_batt_reg) begin
          state_d = ST_FASTCV;
        end
      end
      // fast charge constant voltage, topoff is beyond this block
      ST_FASTCV: begin
        if (wd_expired) begin
          state_d = ST_WDSUSP;
        end
      end
      // timer fault: charging stays off until software restarts it
      ST_TFAULT: begin
        // leave by turning charger off
        if (!ctrl_q[`CTRL_CHG_ON]) begin
          state_d = ST_IDLE;
        end
      end
      // watchdog suspend: charging stays off until serviced
      ST_WDSUSP: begin
        // leave on watchdog clear write
        if (wr && addr == `ADDR_WDCLR && wdata == `WD_CLR_VAL) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // source removal returns to idle from any state
    if (!source_valid || !bat_present) begin
      state_d = ST_IDLE;
    end
  end

  // indicator pattern per state
  // short pulse at the start of each blink period in prequal,
  // steady on in fast charge, off everywhere else
  // the enable bit masks the pattern last so it always wins
  always @* begin
    ind_d = 1'b0;
    case (state_q)
      ST_DEADB, ST_LOWB: ind_d = (blink_q < BLINK_SHORT);
      ST_FASTCC, ST_FASTCV: ind_d = 1'b1;
      default: ind_d = 1'b0;
    endcase
    // topoff and done live outside this machine; off is the done pattern
    if (!ctrl_q[`CTRL_IND_EN]) begin
      ind_d = 1'b0;
    end
  end

  // state, timers and control registers
  // one clocked process holds all state so the clock enable
  // freezes everything in one place
  // shutdown is checked before the enable: a shutdown while
  // frozen still restores the control bits
  // every top-level output is a flip-flop of this process
  always @(posedge mclk) begin
    if (shutdown) begin
      ctrl_q <= `CTRL_RESET;
      ilim_q <= `ILIM_RESET;
      state_q <= ST_IDLE;
      dg_cnt_q <= 32'd0;
      dg_done_q <= 1'b0;
      pq_cnt_q <= 32'd0;
      wd_cnt_q <= 32'd0;
      blink_q <= 32'd0;
      charger_ok_flag_q <= 1'b0;
      bypass_ok_flag_q <= 1'b1;
      charger_detail_field_q <= 4'h8;
      bypass_detail_field_q <= 4'h0;
      vreg_prev_q <= 1'b0;
      charge_indicator_out <= 1'b0;
      buck_on <= 1'b0;
      charger_input_on <= 1'b0;
      ovp_drive <= 1'b0;
      charger_irq <= 1'b0;
      bypass_irq <= 1'b0;
      adapter_type <= AD_NONE;
      rdata <= 8'h00;
    end else if (ce) begin
      state_q <= state_d;
      // register writes
      // only control and limit are writable, other writes leave both registers unchanged
      if (wr) begin
        case (addr)
          `ADDR_CTRL: ctrl_q <= wdata;
          `ADDR_ILIM: ilim_q <= wdata;
          default: ctrl_q <= ctrl_q;
        endcase
      end
      // watchdog timer, cleared by host write
      // only the exact clear value restarts it, other values are ignored
      // the count stops at expiry so the flag cannot wrap away
      if (!ctrl_q[`CTRL_WD_EN] || (wr && addr == `ADDR_WDCLR && wdata == `WD_CLR_VAL)) begin
        wd_cnt_q <= 32'd0;
      end else if (!wd_expired) begin
        wd_cnt_q <= wd_cnt_q + 32'd1;
      end
      // deglitch restarts on every state change
      // a brief visit to dead or fast cc never raises its entry report
      // the counter saturates at the interval to avoid wrap
      if (state_d != state_q) begin
        dg_cnt_q <= 32'd0;
        dg_done_q <= 1'b0;
      end else if (dg_cnt_q < DEGLITCH_CYC) begin
        dg_cnt_q <= dg_cnt_q + 32'd1;
      end
      // prequal timer spans both prequal states
      // it is not restarted on the dead to low move, so a battery
      // stuck in prequal overall still times out
      if (state_q == ST_DEADB || state_q == ST_LOWB) begin
        pq_cnt_q <= pq_cnt_q + 32'd1;
      end else begin
        pq_cnt_q <= 32'd0;
      end
      // one second blink phase
      // free running, the indicator pattern picks its own window
      blink_q <= (blink_q >= BLINK_PERIOD - 1) ? 32'd0 : blink_q + 32'd1;
      // state-entry reports after deglitch
      // the irq output is a one-cycle pulse, cleared by default here
      // dg_done_q blocks a second report while the state holds
      charger_irq <= 1'b0;
      if (state_d == state_q && dg_cnt_q == DEGLITCH_CYC - 1 && !dg_done_q) begin
        dg_done_q <= 1'b1;
        if (state_q == ST_DEADB) begin
          charger_irq <= 1'b1;
          charger_ok_flag_q <= 1'b1;
          charger_detail_field_q <= `DTL_DEADBATT;
        end else if (state_q == ST_FASTCC) begin
          charger_irq <= 1'b1;
          charger_ok_flag_q <= 1'b1;
          charger_detail_field_q <= `DTL_FASTCC;
        end
      end
      // fault states report at once
      // no deglitch here: software must learn of a stop immediately
      if (state_d != state_q && state_d == ST_TFAULT) begin
        charger_irq <= 1'b1;
        charger_ok_flag_q <= 1'b0;
        charger_detail_field_q <= `DTL_TIMERFLT;
      end
      if (state_d != state_q && state_d == ST_WDSUSP) begin
        charger_irq <= 1'b1;
        charger_ok_flag_q <= 1'b0;
        charger_detail_field_q <= `DTL_WDSUSP;
      end
      // input-voltage regulation reporting
      // the irq pulses on the rising edge of regulation only,
      // while the ok flag and detail bit follow the level
      // the lower detail bits are kept while regulation holds
      vreg_prev_q <= vreg_active;
      bypass_irq <= vreg_active & ~vreg_prev_q;
      if (vreg_active) begin
        bypass_ok_flag_q <= 1'b0;
        bypass_detail_field_q <= {1'b1, bypass_detail_field_q[2:0]};
      end else begin
        bypass_ok_flag_q <= source_valid;
        bypass_detail_field_q <= 4'h0;
      end
      // converter in buck mode when a source appears
      // with default limit the source is held to the reset setting
      buck_on <= source_valid;
      // input off when limit at floor and voltage still low
      charger_input_on <= source_valid &&
        !(ilim_q <= `ILIM_OFF && input_below_reg);
      // protection driver follows otp polarity
      ovp_drive <= source_valid ^ otp_ovp_polarity;
      adapter_type <= source_valid ? classify(adapter_sig) : AD_NONE;
      charge_indicator_out <= ind_d;
      // read data, one cycle after strobe
      // rdata returns to zero after one cycle so a stale value
      // is never mistaken for a new read
      // unmapped addresses read as zero, the clear field is write only
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `ADDR_CTRL: rdata <= ctrl_q;
          `ADDR_STATUS: rdata <= {1'b0, state_q};
          `ADDR_DETAIL: rdata <= {bypass_detail_field_q, charger_detail_field_q};
          `ADDR_IRQ: rdata <= {3'b000, adapter_type, bypass_ok_flag_q, charger_ok_flag_q};
          `ADDR_ILIM: rdata <= ilim_q;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== rtl/charger_consts.vh ====
// constants for the charger state and status logic
`ifndef CHARGER_CONSTS_VH
`define CHARGER_CONSTS_VH
// register offsets (4-bit address)
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_DETAIL 4'h2
`define ADDR_IRQ 4'h3
`define ADDR_WDCLR 4'h4
`define ADDR_ILIM 4'h5
// control register fields
`define CTRL_IND_EN 0
`define CTRL_WD_EN 1
`define CTRL_CHG_ON 2
`define CTRL_RESET 8'h05
// input current limit setting, 500 mA default in 33.3 mA steps
`define ILIM_RESET 8'h0f
// input-off current code for 33.3 mA
`define ILIM_OFF 8'h01
// watchdog clear value
`define WD_CLR_VAL 8'h01
// detail codes
`define DTL_DEADBATT 4'h0
`define DTL_FASTCC 4'h1
`define DTL_FASTCV 4'h2
`define DTL_TOPOFF 4'h3
`define DTL_DONE 4'h4
`define DTL_TIMERFLT 4'h6
`define DTL_WDSUSP 4'hb
// timing: times in microseconds, clock 20 MHz
`define CLK_MHZ 20
`define BLINK_PERIOD_US 1000000
`define BLINK_SHORT_US 50000
`define BLINK_PERIOD_CYC (`BLINK_PERIOD_US * `CLK_MHZ)
`define BLINK_SHORT_CYC (`BLINK_SHORT_US * `CLK_MHZ)
`define BLINK_HALF_CYC (`BLINK_PERIOD_CYC / 2)
`endif

// ==== bench/charger_checker_properties.sv ====
// port assertions for the charger state and status logic
`timescale 1ns/100ps
module charger_checker (
  // clock, reset and inputs
  input logic mclk, rst, ce, global_shutdown, source_valid, battery_detect_n,
  input logic input_below_reg, vreg_active, otp_ovp_polarity,
  input logic [2:0] adapter_sig,
  // outputs watched
  input logic [2:0] adapter_type,
  input logic buck_on, charger_input_on, ovp_drive, charger_irq, bypass_irq,
  input logic charge_indicator_out
);
  logic ok, absent_q;
  assign ok = !rst && !global_shutdown && ce;
  // high until a battery is first seen after reset
  always @(posedge mclk) begin
    if (rst)
      absent_q <= 1'b1;
    else if (!battery_detect_n)
      absent_q <= 1'b0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // running long enough that outputs track inputs
  sequence s_run;
    ok && $past(ok) && $past(ok, 2);
  endsequence
  sequence s_vreg_rise;
    ok && $rose(vreg_active);
  endsequence
  AST_BUCK_FOLLOWS:
    assert property (s_run |-> buck_on == $past(source_valid)) else $error("buck wrong");
  AST_OVP_POLARITY:
    assert property (s_run |-> ovp_drive == ($past(source_valid) ^ $past(otp_ovp_polarity)))
    else $error("ovp polarity wrong");
  AST_INPUT_ON:
    assert property (s_run ##0 ($past(source_valid) && !$past(input_below_reg))
      |-> charger_input_on) else $error("input off wrongly");
  AST_INPUT_NO_SOURCE:
    assert property (s_run ##0 !$past(source_valid) |-> !charger_input_on)
    else $error("input on without source");
  AST_ADAPTER_CLASS:
    assert property (s_run |-> adapter_type == (($past(source_valid)
      && $past(adapter_sig) inside {[1:5]}) ? $past(adapter_sig) : 3'h0))
    else $error("adapter class wrong");
  AST_BYP_IRQ_RISE:
    assert property (s_vreg_rise |-> ##[1:3] bypass_irq) else $error("bypass irq missing");
  AST_BYP_IRQ_CAUSE:
    assert property (bypass_irq |-> $past(vreg_active) || $past(vreg_active, 2))
    else $error("bypass irq without regulation");
  AST_CHG_IRQ_PULSE:
    assert property (charger_irq |=> !charger_irq) else $error("charger irq too long");
  AST_NO_BATT_IDLE:
    assert property (absent_q |-> !charger_irq && !charge_indicator_out)
    else $error("activity without battery");
endmodule
bind charger_state_status_logic charger_checker props (.mclk, .rst, .ce, .global_shutdown,
  .source_valid, .battery_detect_n, .input_below_reg, .vreg_active, .otp_ovp_polarity,
  .adapter_sig, .adapter_type, .buck_on, .charger_input_on, .ovp_drive, .charger_irq,
  .bypass_irq, .charge_indicator_out);

// ==== bench/host_irq_model.sv ====
// host side model that counts charger and bypass interrupt pulses
`timescale 1ns/100ps
module host_irq_model (
  input wire mclk, rst, charger_irq, bypass_irq,
  output reg [7:0] chg_seen, byp_seen
);
  // each pulse stands one cycle, so it is taken on that edge
  always @(posedge mclk) begin
    if (rst) begin
      chg_seen <= 8'h00;
      byp_seen <= 8'h00;
    end else begin
      chg_seen <= chg_seen + {7'h00, charger_irq};
      byp_seen <= byp_seen + {7'h00, bypass_irq};
    end
  end
endmodule

// ==== bench/charger_state_status_logic_tb_top.sv ====
// self-checking bench for the charger state and status logic
`timescale 1ns/100ps
module charger_state_status_logic_tb_top;
  logic mclk, rst, ce, global_shutdown, source_valid, battery_detect_n, wr, rd;
  logic above_deadbatt, above_lowbatt, above_batt_reg, input_below_reg;
  logic vreg_active, otp_ovp_polarity;
  logic [2:0] adapter_sig;
  logic [3:0] addr;
  logic [7:0] wdata;
  wire [7:0] rdata, chg_seen, byp_seen;
  wire [2:0] adapter_type;
  wire charge_indicator_out, buck_on, charger_input_on, ovp_drive, charger_irq, bypass_irq;
  integer bad_count = 0, compares = 0, k;
  charger_state_status_logic #(.DEGLITCH_CYC(32'd20), .PREQUAL_CYC(32'd200),
    .WATCHDOG_CYC(32'd100), .BLINK_PERIOD(40), .BLINK_SHORT(4), .BLINK_HALF(20)) uut (
    .mclk, .rst, .ce, .global_shutdown, .source_valid, .battery_detect_n, .above_deadbatt,
    .above_lowbatt, .above_batt_reg, .input_below_reg, .vreg_active, .otp_ovp_polarity,
    .adapter_sig, .addr, .wdata, .wr, .rd, .rdata, .charge_indicator_out, .buck_on,
    .charger_input_on, .ovp_drive, .charger_irq, .bypass_irq, .adapter_type);
  host_irq_model host (.mclk, .rst, .charger_irq, .bypass_irq, .chg_seen, .byp_seen);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task end_of_test;
    begin
      if (bad_count == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  // one-cycle write strobe
  task wr_reg(input [3:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  // read strobe, data taken in the following cycle
  task rd_chk(input [3:0] a, input [7:0] e, input [7:0] m = 8'hff);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(rdata & m, e);
      @(posedge mclk);
    end
  endtask
  // bounded wait for the host to count a charger interrupt
  task wait_irq(input [7:0] e);
    integer i;
    begin
      for (i = 0; i < 100 && chg_seen !== e; i = i + 1)
        @(posedge mclk);
      chk(chg_seen, e);
      if (i == 100)
        end_of_test;
    end
  endtask
  // indicator on-cycles over one blink period
  task ind_count(input [7:0] e);
    integer i;
    reg [7:0] n;
    begin
      n = 8'h00;
      for (i = 0; i < 40; i = i + 1) begin
        @(negedge mclk);
        n = n + {7'h00, charge_indicator_out};
      end
      chk(n, e);
      @(posedge mclk);
    end
  endtask
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    end_of_test;
  end
  initial begin
    {rst, ce, battery_detect_n, wr, rd} = 5'b11100;
    {global_shutdown, source_valid, above_deadbatt, above_lowbatt, above_batt_reg} = 5'h00;
    {input_below_reg, vreg_active, otp_ovp_polarity, adapter_sig} = 6'h00;
    addr = 4'h0;
    wdata = 8'h00;
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    rd_chk(4'h0, 8'h05);
    rd_chk(4'h5, 8'h0f);
    rd_chk(4'hf, 8'h00);
    source_valid <= 1'b1;
    otp_ovp_polarity <= 1'b1;
    for (k = 0; k < 8; k = k + 1) begin
      adapter_sig <= k[2:0];
      cyc(3);
      @(negedge mclk);
      chk({5'h00, adapter_type}, (k > 0 && k < 6) ? k[7:0] : 8'h00);
    end
    chk({7'h00, ovp_drive}, 8'h00);
    chk({7'h00, buck_on}, 8'h01);
    @(posedge mclk);
    rd_chk(4'h1, 8'h01);
    battery_detect_n <= 1'b0;
    cyc(3);
    rd_chk(4'h1, 8'h02);
    wait_irq(8'h01);
    rd_chk(4'h2, 8'h00, 8'h0f);
    ind_count(8'h04);
    above_deadbatt <= 1'b1;
    cyc(3);
    rd_chk(4'h1, 8'h04);
    ind_count(8'h04);
    above_lowbatt <= 1'b1;
    wait_irq(8'h02);
    rd_chk(4'h2, 8'h01, 8'h0f);
    ind_count(8'h28);
    wr_reg(4'h0, 8'h04);
    cyc(1);
    ind_count(8'h00);
    wr_reg(4'h0, 8'h05);
    above_batt_reg <= 1'b1;
    cyc(3);
    rd_chk(4'h1, 8'h10);
    ind_count(8'h28);
    vreg_active <= 1'b1;
    cyc(4);
    chk(byp_seen, 8'h01);
    rd_chk(4'h2, 8'h80, 8'h80);
    rd_chk(4'h3, 8'h00, 8'h02);
    wr_reg(4'h5, 8'h01);
    input_below_reg <= 1'b1;
    cyc(3);
    @(negedge mclk);
    chk({7'h00, charger_input_on}, 8'h00);
    @(posedge mclk);
    {input_below_reg, vreg_active} <= 2'b00;
    wr_reg(4'h5, 8'h0f);
    wr_reg(4'h0, 8'h07);
    cyc(60);
    wr_reg(4'h4, 8'h01);
    cyc(60);
    rd_chk(4'h1, 8'h10);
    cyc(60);
    rd_chk(4'h1, 8'h40);
    wait_irq(8'h03);
    {above_deadbatt, above_lowbatt, above_batt_reg} <= 3'b000;
    global_shutdown <= 1'b1;
    cyc(1);
    global_shutdown <= 1'b0;
    rd_chk(4'h0, 8'h05);
    rd_chk(4'h5, 8'h0f);
    ce <= 1'b0;
    wr_reg(4'h0, 8'h01);
    ce <= 1'b1;
    rd_chk(4'h0, 8'h05);
    cyc(220);
    rd_chk(4'h1, 8'h20);
    end_of_test;
  end
endmodule
